// File: pkg/ulf_pkg.sv
// shared constants and types for the uart line format and fifo trigger block
package ulf_pkg;
  localparam int ULF_AW = 4;
  localparam int ULF_DW = 8;
  localparam int ULF_CW = 7;
  localparam int ULF_IW = 3;

  localparam logic [3:0] ULF_OFS_DATA  = 4'h0;
  localparam logic [3:0] ULF_OFS_DIVH  = 4'h1;
  localparam logic [3:0] ULF_OFS_FIFO  = 4'h2;
  localparam logic [3:0] ULF_OFS_LINE  = 4'h3;
  localparam logic [3:0] ULF_OFS_MODEM = 4'h4;
  localparam logic [3:0] ULF_OFS_ISTS  = 4'h5;
  localparam logic [3:0] ULF_OFS_IMSK  = 4'h6;
  localparam logic [3:0] ULF_OFS_EFR   = 4'h8;
  localparam logic [3:0] ULF_OFS_FIFO_CTL_EXTENSION  = 4'h9;
  localparam logic [3:0] ULF_OFS_TRG   = 4'ha;

  localparam int FC_EN = 0, FC_RXRST = 1, FC_TXRST = 2, FC_DMA = 3;
  localparam int FC_TXT = 4, FC_RXT = 6;
  localparam int LC_STOP = 2, LC_PAR = 3, LC_EVEN = 4, LC_FORCE = 5;
  localparam int LC_BREAK = 6, LC_DIV = 7;
  localparam int MC_DTR = 0, EF_ENH = 4, FX_TBL = 4, FX_TX = 7;
  localparam int IB_RX = 0, IB_TXLOW = 1, IB_TXEMPTY = 2;

  localparam logic [7:0] ULF_REG_RST = 8'h00;
  localparam logic [1:0] ULF_CODE_RST = 2'h0;
  localparam logic [ULF_CW-1:0] ULF_TRG_RST = 7'h01;
  localparam logic [ULF_IW-1:0] ULF_IRQ_RST = 3'h0;
  localparam logic [3:0] ULF_CHAR_BASE = 4'h5;
  localparam logic [2:0] ULF_STOP_ONE = 3'h2;
  localparam logic [2:0] ULF_STOP_HALF = 3'h3;
  localparam logic [2:0] ULF_STOP_TWO = 3'h4;

  typedef enum logic [1:0] {
    ULF_TBL_A = 2'b00,
    ULF_TBL_B = 2'b01,
    ULF_TBL_C = 2'b10,
    ULF_TBL_D = 2'b11
  } ulf_table_e;

  localparam logic [3:0][ULF_CW-1:0] ULF_A_RX = {7'h0e, 7'h08, 7'h04, 7'h01};
  localparam logic [ULF_CW-1:0]      ULF_A_TX = 7'h01;
  localparam logic [3:0][ULF_CW-1:0] ULF_B_RX = {7'h1c, 7'h18, 7'h10, 7'h08};
  localparam logic [3:0][ULF_CW-1:0] ULF_B_TX = {7'h1e, 7'h18, 7'h08, 7'h10};
  localparam logic [3:0][ULF_CW-1:0] ULF_C_RX = {7'h3c, 7'h38, 7'h10, 7'h08};
  localparam logic [3:0][ULF_CW-1:0] ULF_C_TX = {7'h38, 7'h20, 7'h10, 7'h08};
endpackage : ulf_pkg

// File: design/ulf_uart_cfg.sv
// line format, fifo control and trigger logic of one uart channel
`timescale 1ns/1ps
// Contract
// - dma select picks ready pin behaviour
// - tx interrupt below trigger or unfilled empty
// - tx trigger field writable only when enhanced
// - one shared table governs both directions
// - rx interrupt on crossing rx trigger
// - extension bits pick table; table A levels
// - table B rx and tx levels
// - table C rx and tx levels
// - table D uses programmable trigger register
// - word length bits give 5 to 8
// - stop bits one, one and half, two
// - parity enable adds and checks parity
// - even select picks parity sense
// - force bit holds parity constant
// - break holds serial output low
// - divisor access bit redirects shared addresses
// - terminal ready bit drives active low pin
// - fifo fields need enable in same write
module ulf_uart_cfg #(
  parameter int FIFO_DEPTH = 64
) (
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  input  wire logic [ulf_pkg::ULF_AW-1:0]  addr,
  input  wire logic [ulf_pkg::ULF_DW-1:0]  wdata,
  input  wire logic                        wr_en,
  input  wire logic                        rd_en,
  output logic      [ulf_pkg::ULF_DW-1:0]  rdata,
  input  wire logic [ulf_pkg::ULF_DW-1:0]  rx_hold_data,
  output logic                             data_wr,
  output logic                             data_rd,
  output logic      [ulf_pkg::ULF_DW-1:0]  data_wdata,
  output logic      [ulf_pkg::ULF_DW-1:0]  divisor_low,
  output logic      [ulf_pkg::ULF_DW-1:0]  divisor_high,
  output logic      [ulf_pkg::ULF_DW-1:0]  divisor_fraction,
  input  wire logic [ulf_pkg::ULF_CW-1:0]  rx_count,
  input  wire logic [ulf_pkg::ULF_CW-1:0]  tx_count,
  input  wire logic                        rx_timeout,
  input  wire logic                        tx_serial_raw,
  output logic                             txd,
  output logic                             fifo_enable,
  output logic                             rx_fifo_reset,
  output logic                             tx_fifo_reset,
  output logic      [ulf_pkg::ULF_CW-1:0]  rx_trigger,
  output logic      [ulf_pkg::ULF_CW-1:0]  tx_trigger,
  output logic                             tx_ready_pin_b,
  output logic                             rx_ready_pin_b,
  output logic      [3:0]                  char_bits,
  output logic      [2:0]                  stop_half_bits,
  output logic                             parity_enable,
  output logic                             parity_even,
  output logic                             parity_force,
  output logic                             dtr_pin_b,
  output logic                             irq
);
  import ulf_pkg::*;

  function automatic logic [ULF_CW-1:0] trig_lookup(
    input logic [1:0]        tbl,
    input logic [1:0]        code,
    input logic              is_tx,
    input logic [ULF_CW-1:0] prog
  );
    logic [ULF_CW-1:0] lvl;
    lvl = ULF_TRG_RST;
    case (tbl)
      ULF_TBL_A: lvl = is_tx ? ULF_A_TX : ULF_A_RX[code];
      ULF_TBL_B: lvl = is_tx ? ULF_B_TX[code] : ULF_B_RX[code];
      ULF_TBL_C: lvl = is_tx ? ULF_C_TX[code] : ULF_C_RX[code];
      default:   lvl = prog;
    endcase
    return lvl;
  endfunction : trig_lookup

  logic [7:0]        line_ff;
  logic [7:0]        modem_ff;
  logic [7:0]        efr_ff;
  logic [7:0]        fifo_ctl_extension_ff;
  logic              dma_ff;
  logic [1:0]        rx_code_ff;
  logic [1:0]        tx_code_ff;
  logic [ULF_CW-1:0] rx_prog_ff;
  logic [ULF_CW-1:0] tx_prog_ff;
  logic [ULF_IW-1:0] sts_ff;
  logic [ULF_IW-1:0] msk_ff;
  logic [ULF_CW-1:0] rx_prev_ff;
  logic [ULF_CW-1:0] tx_prev_ff;
  logic              filled_ff;
  logic [7:0]        rdata_ff;
  logic [7:0]        divl_ff;
  logic [7:0]        divh_ff;
  logic [7:0]        divf_ff;
  logic              data_wr_ff;
  logic              data_rd_ff;
  logic [7:0]        data_wdata_ff;
  logic              txd_ff;
  logic              fen_ff;
  logic              rxrst_ff;
  logic              txrst_ff;
  logic [ULF_CW-1:0] rx_trig_ff;
  logic [ULF_CW-1:0] tx_trig_ff;
  logic              tx_rdy_b_ff;
  logic              rx_rdy_b_ff;
  logic [3:0]        char_ff;
  logic [2:0]        stop_ff;
  logic              dtr_b_ff;
  logic              irq_ff;

  // address decode
  wire dlab      = line_ff[LC_DIV];
  wire hit_data  = (addr == ULF_OFS_DATA);
  wire hit_divh  = (addr == ULF_OFS_DIVH);
  wire hit_fifo  = (addr == ULF_OFS_FIFO);
  wire wr_line   = wr_en && (addr == ULF_OFS_LINE);
  wire wr_modem  = wr_en && (addr == ULF_OFS_MODEM);
  wire wr_imsk   = wr_en && (addr == ULF_OFS_IMSK);
  wire wr_efr    = wr_en && (addr == ULF_OFS_EFR);
  wire wr_fifo_ctl_extension   = wr_en && (addr == ULF_OFS_FIFO_CTL_EXTENSION);
  wire wr_trg    = wr_en && (addr == ULF_OFS_TRG);
  wire rd_ists   = rd_en && (addr == ULF_OFS_ISTS);
  wire wr_divl   = wr_en && hit_data && dlab;
  wire wr_divh   = wr_en && hit_divh && dlab;
  wire wr_divf   = wr_en && hit_fifo && dlab;
  wire wr_thr    = wr_en && hit_data && !dlab;
  wire rd_rhr    = rd_en && hit_data && !dlab;
  wire wr_fifo   = wr_en && hit_fifo && !dlab;
  wire fifo_prog = wr_fifo && wdata[FC_EN];
  wire tx_prog   = fifo_prog && efr_ff[EF_ENH];

  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = ULF_REG_RST;
    if (hit_data && dlab) begin
      rd_mux = divl_ff;
    end else if (hit_data) begin
      rd_mux = rx_hold_data;
    end else if (hit_divh && dlab) begin
      rd_mux = divh_ff;
    end else if (hit_fifo && dlab) begin
      rd_mux = divf_ff;
    end else if (addr == ULF_OFS_LINE) begin
      rd_mux = line_ff;
    end else if (addr == ULF_OFS_MODEM) begin
      rd_mux = modem_ff;
    end else if (addr == ULF_OFS_ISTS) begin
      rd_mux = {5'h00, sts_ff};
    end else if (addr == ULF_OFS_IMSK) begin
      rd_mux = {5'h00, msk_ff};
    end else if (addr == ULF_OFS_EFR) begin
      rd_mux = efr_ff;
    end else if (addr == ULF_OFS_FIFO_CTL_EXTENSION) begin
      rd_mux = fifo_ctl_extension_ff;
    end else if (addr == ULF_OFS_TRG) begin
      rd_mux = {1'b0, fifo_ctl_extension_ff[FX_TX] ? tx_prog_ff : rx_prog_ff};
    end
  end

  // next values of the software registers
  wire [7:0] nxt_line  = wr_line ? wdata : line_ff;
  wire [7:0] nxt_modem = wr_modem ? wdata : modem_ff;
  wire [1:0] nxt_rxc   = fifo_prog ? wdata[FC_RXT+:2] : rx_code_ff;
  wire [1:0] nxt_txc   = tx_prog ? wdata[FC_TXT+:2] : tx_code_ff;
  wire       nxt_dma   = fifo_prog ? wdata[FC_DMA] : dma_ff;
  // a single table field means the latest selection always serves both sides
  wire [1:0] tbl       = fifo_ctl_extension_ff[FX_TBL+:2];
  wire [ULF_CW-1:0] nxt_rx_prog = (wr_trg && !fifo_ctl_extension_ff[FX_TX]) ?
                                  wdata[ULF_CW-1:0] : rx_prog_ff;
  wire [ULF_CW-1:0] nxt_tx_prog = (wr_trg && fifo_ctl_extension_ff[FX_TX]) ?
                                  wdata[ULF_CW-1:0] : tx_prog_ff;
  wire [ULF_CW-1:0] nxt_rx_trig = trig_lookup(tbl, rx_code_ff, 1'b0, rx_prog_ff);
  wire [ULF_CW-1:0] nxt_tx_trig = trig_lookup(tbl, tx_code_ff, 1'b1, tx_prog_ff);

  // fifo level events, judged against the registered trigger levels
  wire rx_cross = (rx_prev_ff < rx_trig_ff) && (rx_count >= rx_trig_ff);
  wire tx_low   = (tx_prev_ff >= tx_trig_ff) && (tx_count < tx_trig_ff);
  wire tx_empty = (tx_prev_ff != '0) && (tx_count == '0) && !filled_ff;
  wire nxt_filled = (tx_count == '0) ? 1'b0 :
                    (tx_count > tx_trig_ff) ? 1'b1 : filled_ff;
  wire [ULF_IW-1:0] ev = {tx_empty, tx_low, rx_cross};
  // an event in the clearing read's cycle survives the clear
  wire [ULF_IW-1:0] nxt_sts = (rd_ists ? ULF_IRQ_RST : sts_ff) | ev;
  wire [ULF_IW-1:0] nxt_msk = wr_imsk ? wdata[ULF_IW-1:0] : msk_ff;

  // ready pins: normal mode follows fifo state, dma mode uses trigger and space
  wire tx_full = (tx_count >= ULF_CW'(FIFO_DEPTH));
  wire nxt_tx_rdy_b = dma_ff ? tx_full : (tx_count != '0);
  wire rx_dma_b = (rx_count == '0) ? 1'b1 :
                  ((rx_count >= rx_trig_ff) || rx_timeout) ? 1'b0 : rx_rdy_b_ff;
  wire nxt_rx_rdy_b = dma_ff ? rx_dma_b : (rx_count == '0);

  // framing outputs, one set used by transmitter and receiver alike
  wire [3:0] nxt_char = ULF_CHAR_BASE + {2'b00, nxt_line[1:0]};
  wire [2:0] nxt_stop = !nxt_line[LC_STOP] ? ULF_STOP_ONE :
                        (nxt_line[1:0] == 2'b00) ? ULF_STOP_HALF :
                        ULF_STOP_TWO;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      line_ff    <= ULF_REG_RST;
      modem_ff   <= ULF_REG_RST;
      efr_ff     <= ULF_REG_RST;
      fifo_ctl_extension_ff    <= ULF_REG_RST;
      dma_ff     <= 1'b0;
      rx_code_ff <= ULF_CODE_RST;
      tx_code_ff <= ULF_CODE_RST;
      rx_prog_ff <= ULF_TRG_RST;
      tx_prog_ff <= ULF_TRG_RST;
      divl_ff    <= ULF_REG_RST;
      divh_ff    <= ULF_REG_RST;
      divf_ff    <= ULF_REG_RST;
      fen_ff     <= 1'b0;
    end else begin
      line_ff    <= nxt_line;
      modem_ff   <= nxt_modem;
      efr_ff     <= wr_efr ? wdata : efr_ff;
      fifo_ctl_extension_ff    <= wr_fifo_ctl_extension ? wdata : fifo_ctl_extension_ff;
      dma_ff     <= nxt_dma;
      rx_code_ff <= nxt_rxc;
      tx_code_ff <= nxt_txc;
      rx_prog_ff <= nxt_rx_prog;
      tx_prog_ff <= nxt_tx_prog;
      divl_ff    <= wr_divl ? wdata : divl_ff;
      divh_ff    <= wr_divh ? wdata : divh_ff;
      divf_ff    <= wr_divf ? wdata : divf_ff;
      fen_ff     <= wr_fifo ? wdata[FC_EN] : fen_ff;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sts_ff      <= ULF_IRQ_RST;
      msk_ff      <= ULF_IRQ_RST;
      irq_ff      <= 1'b0;
      rx_prev_ff  <= '0;
      tx_prev_ff  <= '0;
      filled_ff   <= 1'b0;
      rx_trig_ff  <= ULF_TRG_RST;
      tx_trig_ff  <= ULF_TRG_RST;
      tx_rdy_b_ff <= 1'b1;
      rx_rdy_b_ff <= 1'b1;
    end else begin
      sts_ff      <= nxt_sts;
      msk_ff      <= nxt_msk;
      irq_ff      <= |(nxt_sts & nxt_msk);
      rx_prev_ff  <= rx_count;
      tx_prev_ff  <= tx_count;
      filled_ff   <= nxt_filled;
      rx_trig_ff  <= nxt_rx_trig;
      tx_trig_ff  <= nxt_tx_trig;
      tx_rdy_b_ff <= nxt_tx_rdy_b;
      rx_rdy_b_ff <= nxt_rx_rdy_b;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_ff      <= ULF_REG_RST;
      data_wr_ff    <= 1'b0;
      data_rd_ff    <= 1'b0;
      data_wdata_ff <= ULF_REG_RST;
      rxrst_ff      <= 1'b0;
      txrst_ff      <= 1'b0;
      txd_ff        <= 1'b1;
      char_ff       <= ULF_CHAR_BASE;
      stop_ff       <= ULF_STOP_ONE;
      dtr_b_ff      <= 1'b1;
    end else begin
      rdata_ff      <= rd_en ? rd_mux : ULF_REG_RST;
      data_wr_ff    <= wr_thr;
      data_rd_ff    <= rd_rhr;
      data_wdata_ff <= wr_thr ? wdata : data_wdata_ff;
      rxrst_ff      <= fifo_prog && wdata[FC_RXRST];
      txrst_ff      <= fifo_prog && wdata[FC_TXRST];
      txd_ff        <= tx_serial_raw && !nxt_line[LC_BREAK];
      char_ff       <= nxt_char;
      stop_ff       <= nxt_stop;
      dtr_b_ff      <= !nxt_modem[MC_DTR];
    end
  end

  assign rdata            = rdata_ff;
  assign data_wr          = data_wr_ff;
  assign data_rd          = data_rd_ff;
  assign data_wdata       = data_wdata_ff;
  assign divisor_low      = divl_ff;
  assign divisor_high     = divh_ff;
  assign divisor_fraction = divf_ff;
  assign txd              = txd_ff;
  assign fifo_enable      = fen_ff;
  assign rx_fifo_reset    = rxrst_ff;
  assign tx_fifo_reset    = txrst_ff;
  assign rx_trigger       = rx_trig_ff;
  assign tx_trigger       = tx_trig_ff;
  assign tx_ready_pin_b   = tx_rdy_b_ff;
  assign rx_ready_pin_b   = rx_rdy_b_ff;
  assign char_bits        = char_ff;
  assign stop_half_bits   = stop_ff;
  // parity controls are shared by the generator and the checker
  assign parity_enable    = line_ff[LC_PAR];
  assign parity_even      = line_ff[LC_EVEN];
  assign parity_force     = line_ff[LC_FORCE];
  assign dtr_pin_b        = dtr_b_ff;
  assign irq              = irq_ff;

  property p_break_low;
    @(posedge clk) disable iff (!rst_b)
    line_ff[LC_BREAK] [*2] |-> !txd_ff;
  endproperty
  a_break_low: assert property (p_break_low)
    else $error("break set but serial output not low");

  property p_fifo_gate;
    @(posedge clk) disable iff (!rst_b)
    (wr_fifo && !wdata[FC_EN]) |=> $stable(rx_code_ff) && $stable(dma_ff);
  endproperty
  a_fifo_gate: assert property (p_fifo_gate)
    else $error("fifo fields changed without enable");

  property p_tx_gate;
    @(posedge clk) disable iff (!rst_b)
    (wr_fifo && !efr_ff[EF_ENH]) |=> $stable(tx_code_ff);
  endproperty
  a_tx_gate: assert property (p_tx_gate)
    else $error("tx trigger field written while not enhanced");

  property p_dtr;
    @(posedge clk) disable iff (!rst_b)
    wr_modem |=> (dtr_pin_b == !$past(wdata[MC_DTR]));
  endproperty
  a_dtr: assert property (p_dtr)
    else $error("terminal ready pin not following control bit");

  property p_rx_irq;
    @(posedge clk) disable iff (!rst_b)
    rx_cross |=> sts_ff[IB_RX];
  endproperty
  a_rx_irq: assert property (p_rx_irq)
    else $error("rx trigger crossing lost");

  property p_tx_irq;
    @(posedge clk) disable iff (!rst_b)
    (tx_low || tx_empty) |=> (sts_ff[IB_TXLOW] || sts_ff[IB_TXEMPTY]);
  endproperty
  a_tx_irq: assert property (p_tx_irq)
    else $error("tx trigger event lost");

  property p_char;
    @(posedge clk) disable iff (!rst_b)
    char_bits == ULF_CHAR_BASE + {2'b00, line_ff[1:0]};
  endproperty
  a_char: assert property (p_char)
    else $error("character length mismatch");

  property p_stop;
    @(posedge clk) disable iff (!rst_b)
    (line_ff[LC_STOP] && line_ff[1:0] == 2'b00) |-> stop_half_bits == ULF_STOP_HALF;
  endproperty
  a_stop: assert property (p_stop)
    else $error("five bit characters lack one and half stop bits");

  property p_tbl_a;
    @(posedge clk) disable iff (!rst_b)
    (tbl == ULF_TBL_A) [*2] |-> tx_trig_ff == ULF_A_TX;
  endproperty
  a_tbl_a: assert property (p_tbl_a)
    else $error("table A transmit level not one");

  property p_steer;
    @(posedge clk) disable iff (!rst_b)
    (wr_trg && fifo_ctl_extension_ff[FX_TX]) |=> $stable(rx_prog_ff);
  endproperty
  a_steer: assert property (p_steer)
    else $error("transmit trigger write reached receive level");

  property p_divsel;
    @(posedge clk) disable iff (!rst_b)
    (wr_en && hit_data && dlab) |=> !data_wr && divisor_low == $past(wdata);
  endproperty
  a_divsel: assert property (p_divsel)
    else $error("divisor access reached data register");

  property p_dma_tx;
    @(posedge clk) disable iff (!rst_b)
    (!dma_ff && tx_count == '0) |=> !tx_ready_pin_b;
  endproperty
  a_dma_tx: assert property (p_dma_tx)
    else $error("normal mode tx ready not low on empty fifo");
endmodule : ulf_uart_cfg

// File: verif/ulf_far_model.sv
// far side model: fifo fill counts, receive holding byte and transmit shifter
`timescale 1ns/1ps
module ulf_far_model #(
  parameter logic [7:0] HOLD_BYTE = 8'h3c
) (
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  input  wire logic [ulf_pkg::ULF_CW-1:0] rx_goal,
  input  wire logic [ulf_pkg::ULF_CW-1:0] tx_goal,
  input  wire logic                       rx_fifo_reset,
  input  wire logic                       tx_fifo_reset,
  output logic      [ulf_pkg::ULF_CW-1:0] rx_count,
  output logic      [ulf_pkg::ULF_CW-1:0] tx_count,
  output logic      [ulf_pkg::ULF_DW-1:0] rx_hold_data,
  output logic                            tx_serial_raw
);
  import ulf_pkg::*;
  assign rx_hold_data = HOLD_BYTE;
  // counts move one step a cycle so every trigger crossing is seen
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_count <= '0;
      tx_count <= '0;
      tx_serial_raw <= 1'b1;
    end else begin
      // shifter output changes every cycle so a stuck copy is caught
      tx_serial_raw <= !tx_serial_raw;
      if (rx_fifo_reset) rx_count <= '0;
      else if (rx_count < rx_goal) rx_count <= rx_count + 7'h01;
      else if (rx_count > rx_goal) rx_count <= rx_count - 7'h01;
      if (tx_fifo_reset) tx_count <= '0;
      else if (tx_count < tx_goal) tx_count <= tx_count + 7'h01;
      else if (tx_count > tx_goal) tx_count <= tx_count - 7'h01;
    end
  end
endmodule : ulf_far_model

// File: verif/tb_top.sv
// self-checking bench for the line format and fifo trigger block
`timescale 1ns/1ps
module tb_top;
  import ulf_pkg::*;
  logic clk, rst_b, wr_en, rd_en, txd, fifo_enable, rx_rst, tx_rst, irq, data_wr;
  logic tx_rdy_b, rx_rdy_b, par_en, par_even, par_force, dtr_b, raw, drd;
  logic [3:0] addr, char_bits;
  logic [2:0] stop_half;
  logic [7:0] wdata, rdata, hold, dwdata, dl, dh, df, d;
  logic [6:0] rx_cnt, tx_cnt, rx_goal, tx_goal, rx_trig, tx_trig;
  int mismatches, total_checks, cyc;
  int rxt[3][4] = '{'{1, 4, 8, 14}, '{8, 16, 24, 28}, '{8, 16, 56, 60}};
  int txt[3][4] = '{'{1, 1, 1, 1}, '{16, 8, 24, 30}, '{8, 16, 32, 56}};

  ulf_uart_cfg #(.FIFO_DEPTH(64)) u_ulf_uart_cfg (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .rx_hold_data(hold), .data_wr(data_wr), .data_rd(drd), .data_wdata(dwdata),
    .divisor_low(dl), .divisor_high(dh), .divisor_fraction(df), .rx_count(rx_cnt),
    .tx_count(tx_cnt), .rx_timeout(1'b0), .tx_serial_raw(raw), .txd(txd),
    .fifo_enable(fifo_enable), .rx_fifo_reset(rx_rst), .tx_fifo_reset(tx_rst),
    .rx_trigger(rx_trig), .tx_trigger(tx_trig), .tx_ready_pin_b(tx_rdy_b),
    .rx_ready_pin_b(rx_rdy_b), .char_bits(char_bits), .stop_half_bits(stop_half),
    .parity_enable(par_en), .parity_even(par_even), .parity_force(par_force),
    .dtr_pin_b(dtr_b), .irq(irq));

  ulf_far_model u_ulf_far_model (
    .clk(clk), .rst_b(rst_b), .rx_goal(rx_goal), .tx_goal(tx_goal), .rx_fifo_reset(rx_rst),
    .tx_fifo_reset(tx_rst), .rx_count(rx_cnt), .tx_count(tx_cnt), .rx_hold_data(hold),
    .tx_serial_raw(raw));

  initial begin
    clk = 1'b0;
    forever #4 clk = !clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 v = rdata;
  endtask : rd

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_cyc

  task automatic goals(input logic [6:0] r, input logic [6:0] t);
    @(posedge clk);
    rx_goal <= r;
    tx_goal <= t;
    wait_cyc(8);
  endtask : goals

  task automatic test_reset;
    chk(rx_trig, 8'h01, "rx trigger default");
    chk(tx_trig, 8'h01, "tx trigger default");
    chk(char_bits, 8'h05, "char default");
    chk(dtr_b, 1'b1, "dtr default");
    rd(ULF_OFS_FIFO, d);
    chk(d, 8'h00, "fifo control reads zero");
    rd(4'h7, d);
    chk(d, 8'h00, "unmapped read");
    $display("test reset done");
  endtask : test_reset

  task automatic test_irq;
    wr(ULF_OFS_FIFO, 8'h01);
    wr(ULF_OFS_IMSK, 8'h06);
    goals(7'd2, 7'd0);
    chk(irq, 1'b0, "masked rx irq");
    rd(ULF_OFS_ISTS, d);
    chk(d, 8'h01, "rx crossing status");
    rd(ULF_OFS_ISTS, d);
    chk(d, 8'h00, "status cleared by read");
    goals(7'd2, 7'd1);
    goals(7'd2, 7'd0);
    chk(irq, 1'b1, "tx irq raised");
    rd(ULF_OFS_ISTS, d);
    chk(d, 8'h06, "tx low and unfilled empty");
    chk(irq, 1'b0, "irq drops after read");
    goals(7'd2, 7'd3);
    goals(7'd2, 7'd0);
    rd(ULF_OFS_ISTS, d);
    chk(d, 8'h02, "filled above trigger, no empty flag");
    wr(ULF_OFS_IMSK, 8'h07);
    goals(7'd0, 7'd0);
    goals(7'd1, 7'd0);
    chk(irq, 1'b1, "unmasked rx irq");
    rd(ULF_OFS_ISTS, d);
    chk(d, 8'h01, "unmasked rx crossing status");
    $display("test irq done");
  endtask : test_irq

  task automatic test_line;
    logic [3:0] ec;
    logic [2:0] es;
    for (int k = 0; k < 64; k++) begin
      wr(ULF_OFS_LINE, 8'(k));
      wait_cyc(1);
      ec = 4'(5 + k % 4);
      es = (k & 4) == 0 ? 3'h2 : (k % 4 == 0 ? 3'h3 : 3'h4);
      chk(char_bits, ec, "word length");
      chk(stop_half, es, "stop length");
      chk(par_en, k[3], "parity enable");
      chk(par_even, k[4], "parity sense");
      chk(par_force, k[5], "parity force");
      rd(ULF_OFS_LINE, d);
      chk(d, 8'(k), "line readback");
    end
    $display("test line done");
  endtask : test_line

  task automatic test_break;
    logic prev;
    wr(ULF_OFS_LINE, 8'h40);
    for (int i = 0; i < 6; i++) begin
      wait_cyc(1);
      chk(txd, 1'b0, "break holds line low");
    end
    wr(ULF_OFS_LINE, 8'h00);
    wait_cyc(1);
    for (int i = 0; i < 4; i++) begin
      prev = raw;
      wait_cyc(1);
      chk(txd, prev, "serial follows shifter");
    end
    $display("test break done");
  endtask : test_break

  task automatic test_divisor;
    wr(ULF_OFS_LINE, 8'h80);
    wr(ULF_OFS_DATA, 8'h12);
    #1 chk(data_wr, 1'b0, "no data write in divisor mode");
    wr(ULF_OFS_DIVH, 8'h34);
    wr(ULF_OFS_FIFO, 8'h56);
    wait_cyc(1);
    chk(dl, 8'h12, "divisor low");
    chk(dh, 8'h34, "divisor high");
    chk(df, 8'h56, "divisor fraction");
    rd(ULF_OFS_DATA, d);
    chk(d, 8'h12, "divisor low readback");
    chk(drd, 1'b0, "no data read in divisor mode");
    wr(ULF_OFS_LINE, 8'h00);
    wr(ULF_OFS_DATA, 8'ha5);
    #1 chk(data_wr, 1'b1, "data write pulse");
    chk(dwdata, 8'ha5, "data write value");
    rd(ULF_OFS_DATA, d);
    chk(d, 8'h3c, "receive holding byte");
    chk(drd, 1'b1, "data read pulse");
    wr(ULF_OFS_MODEM, 8'h01);
    wait_cyc(1);
    chk(dtr_b, 1'b0, "dtr driven low");
    wr(ULF_OFS_MODEM, 8'h00);
    wait_cyc(1);
    chk(dtr_b, 1'b1, "dtr released high");
    $display("test divisor done");
  endtask : test_divisor

  task automatic test_trig;
    wr(ULF_OFS_EFR, 8'h10);
    for (int t = 0; t < 3; t++) begin
      for (int c = 0; c < 4; c++) begin
        wr(ULF_OFS_FIFO_CTL_EXTENSION, 8'(t << 4));
        wr(ULF_OFS_FIFO, 8'((c << 6) | (c << 4) | 1));
        wait_cyc(2);
        chk(rx_trig, 8'(rxt[t][c]), "rx level");
        chk(tx_trig, 8'(txt[t][c]), "tx level");
      end
    end
    wr(ULF_OFS_FIFO_CTL_EXTENSION, 8'h10);
    wait_cyc(2);
    chk(rx_trig, 8'd28, "last table governs rx");
    chk(tx_trig, 8'd30, "last table governs tx");
    wr(ULF_OFS_EFR, 8'h00);
    wr(ULF_OFS_FIFO, 8'h01);
    wait_cyc(2);
    chk(rx_trig, 8'd8, "rx field still open");
    chk(tx_trig, 8'd30, "tx field locked");
    wr(ULF_OFS_FIFO, 8'hc0);
    wait_cyc(2);
    chk(rx_trig, 8'd8, "fields need enable");
    chk(fifo_enable, 1'b0, "fifo disabled");
    wr(ULF_OFS_FIFO_CTL_EXTENSION, 8'h30);
    wr(ULF_OFS_TRG, 8'h14);
    wr(ULF_OFS_FIFO_CTL_EXTENSION, 8'hb0);
    wr(ULF_OFS_TRG, 8'h2a);
    wait_cyc(2);
    chk(rx_trig, 8'h14, "programmable rx level");
    chk(tx_trig, 8'h2a, "programmable tx level");
    rd(ULF_OFS_TRG, d);
    chk(d, 8'h2a, "steered trigger readback");
    $display("test trig done");
  endtask : test_trig

  task automatic test_dma;
    wr(ULF_OFS_FIFO_CTL_EXTENSION, 8'h00);
    wr(ULF_OFS_FIFO, 8'h81);
    goals(7'd3, 7'd0);
    chk(rx_rdy_b, 1'b0, "normal rx ready");
    chk(tx_rdy_b, 1'b0, "normal tx empty ready");
    goals(7'd3, 7'd3);
    chk(tx_rdy_b, 1'b1, "normal tx not empty");
    wr(ULF_OFS_FIFO, 8'h89);
    // dma rx pin holds low until the fifo empties, so drain before the below-level check
    goals(7'd0, 7'd3);
    goals(7'd3, 7'd3);
    chk(rx_rdy_b, 1'b1, "dma rx below level");
    chk(tx_rdy_b, 1'b0, "dma tx room left");
    goals(7'd9, 7'd3);
    chk(rx_rdy_b, 1'b0, "dma rx at level");
    wr(ULF_OFS_FIFO, 8'h8f);
    #1 chk(rx_rst, 1'b1, "rx fifo reset pulse");
    chk(tx_rst, 1'b1, "tx fifo reset pulse");
    wr(ULF_OFS_FIFO, 8'h06);
    #1 chk(rx_rst, 1'b0, "rx reset needs enable");
    chk(tx_rst, 1'b0, "tx reset needs enable");
    $display("test dma done");
  endtask : test_dma

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  // a hung handshake must not stall the run forever
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  initial begin
    rst_b = 1'b0;
    addr = '0;
    wdata = '0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    rx_goal = '0;
    tx_goal = '0;
    mismatches = 0;
    total_checks = 0;
    cyc = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    wait_cyc(1);
    test_reset();
    test_irq();
    test_line();
    test_break();
    test_divisor();
    test_trig();
    test_dma();
    end_of_test();
  end
endmodule : tb_top
